// file: common/ssw_pkg.sv
package ssw_pkg;

	// ----------------------------------------------------------------
	// Clock and unit scaling
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS    = 100;
	localparam int NS_PER_US        = 1000;
	localparam int NS_PER_MS        = 1000000;
	localparam int CNT_W            = 32;

	// ----------------------------------------------------------------
	// Times as specified
	// ----------------------------------------------------------------
	localparam int T_HOLD_MS        = 200;
	localparam int T_WD_OPEN_MS     = 1600;
	localparam int T_WD_OPEN_MIN_MS = 1360;
	localparam int T_WD_OPEN_MAX_MS = 1840;
	localparam int T_WD_RES_MS      = 200;
	localparam int T_WD_RES_MIN_MS  = 170;
	localparam int T_WD_RES_MAX_MS  = 230;
	localparam int T_INIT_US        = 381;
	localparam int T_SETUP_US       = 150;
	localparam int T_STD_SLOPE_US   = 3230;
	localparam int T_STD_BASE_US    = 381;
	localparam int T_EXT_SLOPE_US   = 77400;
	localparam int T_EXT_BASE_MS    = 55;
	localparam int CAP_UNITS_PER_NF = 10;

	// ----------------------------------------------------------------
	// Derived cycle counts
	// ----------------------------------------------------------------
	localparam int HOLD_CYC      = T_HOLD_MS * (NS_PER_MS / CLK_PERIOD_NS);
	localparam int WD_OPEN_CYC   = T_WD_OPEN_MS * (NS_PER_MS / CLK_PERIOD_NS);
	localparam int WD_RES_CYC    = T_WD_RES_MS * (NS_PER_MS / CLK_PERIOD_NS);
	localparam int INIT_CYC      = (T_INIT_US * NS_PER_US) / CLK_PERIOD_NS;
	localparam int SETUP_CYC     = (T_SETUP_US * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STD_SLOPE_CYC = (T_STD_SLOPE_US * NS_PER_US)
		/ (CLK_PERIOD_NS * CAP_UNITS_PER_NF);
	localparam int STD_BASE_CYC  = (T_STD_BASE_US * NS_PER_US) / CLK_PERIOD_NS;
	localparam int EXT_SLOPE_CYC = (T_EXT_SLOPE_US * NS_PER_US)
		/ (CLK_PERIOD_NS * CAP_UNITS_PER_NF);
	localparam int EXT_BASE_CYC  = T_EXT_BASE_MS * (NS_PER_MS / CLK_PERIOD_NS);

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam int          ADDR_W       = 4;
	localparam logic [3:0]  REG_CTRL     = 4'h0;
	localparam logic [3:0]  REG_CAP      = 4'h4;
	localparam logic [3:0]  REG_STATUS   = 4'h8;
	localparam int          CTRL_EXT_BIT = 0;
	localparam int          CAP_W        = 14;
	localparam logic [13:0] CAP_RESET    = 14'h000a;
	localparam int          ST_RST_BIT   = 0;
	localparam int          ST_FAULT_BIT = 1;
	localparam int          ST_RUN_BIT   = 2;
	localparam int          ST_EVAL_BIT  = 3;
	localparam int          ST_CFG_LSB   = 4;
	localparam int          ST_SETUP_BIT = 6;
	localparam int          ST_CFGOK_BIT = 7;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		CFG_OPEN   = 2'h0,
		CFG_PULLUP = 2'h1,
		CFG_CAP    = 2'h2
	} ssw_cfg_t;

	typedef enum logic [2:0] {
		ST_DOWN = 3'h1,
		ST_HOLD = 3'h2,
		ST_RUN  = 3'h4
	} ssw_state_t;

endpackage

// file: core/ssw_supervisor.sv
`timescale 1ns/1ps
`default_nettype none

module ssw_supervisor
	import ssw_pkg::*;
#(
	parameter int HOLD_CYCLES      = HOLD_CYC,
	parameter int WD_OPEN_CYCLES   = WD_OPEN_CYC,
	parameter int WD_RES_CYCLES    = WD_RES_CYC,
	parameter int STD_SLOPE_CYCLES = STD_SLOPE_CYC,
	parameter int STD_BASE_CYCLES  = STD_BASE_CYC,
	parameter int EXT_SLOPE_CYCLES = EXT_SLOPE_CYC,
	parameter int EXT_BASE_CYCLES  = EXT_BASE_CYC
) (
	input  wire logic              sys_clk,
	input  wire logic              rst,
	input  wire logic              clk_en,
	input  wire logic              supply_min_ok,
	input  wire logic              supply_above_thr,
	input  wire logic              supply_above_hyst,
	input  wire logic              manual_reset_n,
	input  wire logic              manual_reset_n_oe,
	input  wire logic [1:0]        timeout_config_pin,
	input  wire logic              watchdog_enable_select,
	input  wire logic              watchdog_kick_in,
	output logic                   sys_reset_n_o,
	output logic                   sys_reset_n_oe,
	output logic                   watchdog_fault_n_o,
	output logic                   watchdog_fault_n_oe,
	input  wire logic [ADDR_W-1:0] avs_address,
	input  wire logic              avs_read,
	input  wire logic              avs_write,
	input  wire logic [31:0]       avs_writedata,
	input  wire logic [3:0]        avs_byteenable,
	output logic [31:0]            avs_readdata,
	output logic                   avs_waitrequest
);

	// ----------------------------------------------------------------
	// Elaboration checks
	// ----------------------------------------------------------------
	if (HOLD_CYCLES < 1 || WD_OPEN_CYCLES < 1 || WD_RES_CYCLES < 1) begin : g_chk_cnt
		$error("ssw_supervisor: cycle counts must be at least 1");
	end
	if (longint'(EXT_SLOPE_CYCLES) * ((1 << CAP_W) - 1) + EXT_BASE_CYCLES
			>= (longint'(1) << CNT_W)) begin : g_chk_cap
		$error("ssw_supervisor: capacitor timeout overflows counter");
	end

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	ssw_state_t       state_q;
	ssw_state_t       state_d;
	ssw_cfg_t         cfg_q;
	logic             cfg_ok_q;
	logic             hyst_q;
	logic             eval_busy_q;
	logic             sel_q;
	logic             setup_busy_q;
	logic             kick_q;
	logic             fault_q;
	logic             ext_q;
	logic [CAP_W-1:0] cap_q;
	logic             wait_q;
	logic [31:0]      rdata_q;
	logic             rst_n_o_q;
	logic             rst_n_oe_q;
	logic             flt_n_o_q;
	logic             flt_n_oe_q;

	logic             mr_active;
	logic             supply_low;
	logic             may_release;
	logic             hold_exp;
	logic             eval_start;
	logic             eval_exp;
	logic             eval_busy_d;
	logic             sel_rise;
	logic             setup_exp;
	logic             setup_busy_d;
	logic             kick_fall;
	logic             wd_run;
	logic             kick_ok;
	logic             wd_exp;
	logic             fault_exp;
	logic             fault_d;
	logic             run_d;
	logic [CNT_W-1:0] cap_std;
	logic [CNT_W-1:0] cap_ext;
	logic [CNT_W-1:0] cap_lim;
	logic [CNT_W-1:0] wd_lim;

	logic             req;
	logic             rd_load;
	logic             wr_do;
	logic             hit_ctrl;
	logic             hit_cap;
	logic             hit_status;
	logic [31:0]      be_mask;
	logic [31:0]      ctrl_word;
	logic [31:0]      cap_word;
	logic [31:0]      status_word;
	logic [31:0]      rd_mux;
	logic [31:0]      ctrl_new;
	logic [31:0]      cap_new;

	// ----------------------------------------------------------------
	// Supply and manual reset decode
	// ----------------------------------------------------------------
	// A host that does not drive the pin leaves it pulled inactive
	assign mr_active   = manual_reset_n_oe && !manual_reset_n;
	assign supply_low  = !supply_min_ok || !supply_above_thr;
	// Release needs the upper, hysteresis-raised level, not just the threshold
	assign may_release = supply_min_ok && supply_above_hyst && !mr_active;

	// ----------------------------------------------------------------
	// Reset sequencer
	// ----------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			ST_DOWN: begin
				if (may_release) begin
					state_d = ST_HOLD;
				end
			end
			ST_HOLD: begin
				if (supply_low || mr_active) begin
					state_d = ST_DOWN;
				end else if (hold_exp) begin
					state_d = ST_RUN;
				end
			end
			ST_RUN: begin
				// Watchdog state has no path into here
				if (supply_low || mr_active) begin
					state_d = ST_DOWN;
				end
			end
			default: begin
				state_d = ST_DOWN;
			end
		endcase
	end

	assign run_d = (state_d == ST_RUN);

	ssw_tick_count #(
		.W       (CNT_W)
	) u_hold (
		.sys_clk (sys_clk),
		.rst     (rst),
		.clk_en  (clk_en),
		.clear   (state_q != ST_HOLD),
		.run     (1'b1),
		.limit   (CNT_W'(HOLD_CYCLES)),
		.expired (hold_exp)
	);

	// ----------------------------------------------------------------
	// Timing pin evaluation
	// ----------------------------------------------------------------
	assign eval_start  = supply_above_hyst && !hyst_q;
	assign eval_busy_d = eval_start || (eval_busy_q && !eval_exp);

	ssw_tick_count #(
		.W       (CNT_W)
	) u_eval (
		.sys_clk (sys_clk),
		.rst     (rst),
		.clk_en  (clk_en),
		.clear   (eval_start),
		.run     (eval_busy_q),
		.limit   (CNT_W'(INIT_CYC)),
		.expired (eval_exp)
	);

	// ----------------------------------------------------------------
	// Timeout selection
	// ----------------------------------------------------------------
	assign cap_std = CNT_W'(CNT_W'(cap_q) * CNT_W'(STD_SLOPE_CYCLES)
		+ CNT_W'(STD_BASE_CYCLES));
	assign cap_ext = CNT_W'(CNT_W'(cap_q) * CNT_W'(EXT_SLOPE_CYCLES)
		+ CNT_W'(EXT_BASE_CYCLES));
	assign cap_lim = ext_q ? cap_ext : cap_std;
	// Unknown class code falls back to the longest factory timeout
	assign wd_lim  = (cfg_q == CFG_CAP)    ? cap_lim :
	                 (cfg_q == CFG_PULLUP) ? CNT_W'(WD_RES_CYCLES) :
	                                         CNT_W'(WD_OPEN_CYCLES);

	// ----------------------------------------------------------------
	// Watchdog
	// ----------------------------------------------------------------
	assign sel_rise     = watchdog_enable_select && !sel_q;
	assign setup_busy_d = sel_rise || (setup_busy_q && !setup_exp);

	ssw_tick_count #(
		.W       (CNT_W)
	) u_setup (
		.sys_clk (sys_clk),
		.rst     (rst),
		.clk_en  (clk_en),
		.clear   (sel_rise),
		.run     (setup_busy_q),
		.limit   (CNT_W'(SETUP_CYC)),
		.expired (setup_exp)
	);

	// The timer is idle without a settled class; a stale one would time wrongly
	assign wd_run    = watchdog_enable_select && (state_q == ST_RUN)
		&& cfg_ok_q && !eval_busy_q;
	// Sampled every cycle: a host level shorter than one period may be missed
	assign kick_fall = kick_q && !watchdog_kick_in;
	assign kick_ok   = kick_fall && wd_run && !setup_busy_q && !fault_q;

	ssw_tick_count #(
		.W       (CNT_W)
	) u_wd (
		.sys_clk (sys_clk),
		.rst     (rst),
		.clk_en  (clk_en),
		.clear   (!wd_run || kick_ok || fault_q),
		.run     (1'b1),
		.limit   (wd_lim),
		.expired (wd_exp)
	);

	ssw_tick_count #(
		.W       (CNT_W)
	) u_fault (
		.sys_clk (sys_clk),
		.rst     (rst),
		.clk_en  (clk_en),
		.clear   (!fault_q),
		.run     (1'b1),
		.limit   (CNT_W'(HOLD_CYCLES)),
		.expired (fault_exp)
	);

	// Gated by the next state too, so fault and reset are never driven together
	assign fault_d = wd_run && run_d && (fault_q ? !fault_exp : wd_exp);

	// ----------------------------------------------------------------
	// Register bus decode
	// ----------------------------------------------------------------
	assign req        = avs_read || avs_write;
	assign rd_load    = avs_read && wait_q;
	assign wr_do      = avs_write && !avs_read && !wait_q;
	assign hit_ctrl   = (avs_address == REG_CTRL);
	assign hit_cap    = (avs_address == REG_CAP);
	assign hit_status = (avs_address == REG_STATUS);
	assign be_mask    = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
	                     {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

	assign ctrl_word  = 32'(ext_q) << CTRL_EXT_BIT;
	assign cap_word   = 32'(cap_q);
	assign status_word = (32'(state_q != ST_RUN) << ST_RST_BIT)
		| (32'(fault_q) << ST_FAULT_BIT)
		| (32'(wd_run) << ST_RUN_BIT)
		| (32'(eval_busy_q) << ST_EVAL_BIT)
		| (32'(cfg_q) << ST_CFG_LSB)
		| (32'(setup_busy_q) << ST_SETUP_BIT)
		| (32'(cfg_ok_q) << ST_CFGOK_BIT);

	// Unmapped reads return zero, writes there are dropped
	assign rd_mux   = hit_ctrl   ? ctrl_word :
	                  hit_cap    ? cap_word :
	                  hit_status ? status_word : 32'h0000_0000;
	assign ctrl_new = (ctrl_word & ~be_mask) | (avs_writedata & be_mask);
	assign cap_new  = (cap_word & ~be_mask) | (avs_writedata & be_mask);

	// ----------------------------------------------------------------
	// State registers
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state_q      <= ST_DOWN;
			hyst_q       <= 1'b0;
			eval_busy_q  <= 1'b0;
			sel_q        <= 1'b0;
			setup_busy_q <= 1'b0;
			kick_q       <= 1'b0;
			fault_q      <= 1'b0;
		end else if (clk_en) begin
			state_q      <= state_d;
			hyst_q       <= supply_above_hyst;
			eval_busy_q  <= eval_busy_d;
			sel_q        <= watchdog_enable_select;
			setup_busy_q <= setup_busy_d;
			kick_q       <= watchdog_kick_in;
			fault_q      <= fault_d;
		end
	end

	// Class is latched when evaluation finishes
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cfg_q    <= CFG_OPEN;
			cfg_ok_q <= 1'b0;
		end else if (clk_en) begin
			if (eval_start) begin
				cfg_ok_q <= 1'b0;
			end else if (eval_busy_q && eval_exp) begin
				cfg_q    <= ssw_cfg_t'(timeout_config_pin);
				cfg_ok_q <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Software registers and bus handshake
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ext_q   <= 1'b0;
			cap_q   <= CAP_RESET;
			wait_q  <= 1'b1;
			rdata_q <= 32'h0000_0000;
		end else if (clk_en) begin
			wait_q <= req ? !wait_q : 1'b1;
			if (rd_load) begin
				rdata_q <= rd_mux;
			end
			if (wr_do && hit_ctrl) begin
				ext_q <= ctrl_new[CTRL_EXT_BIT];
			end
			if (wr_do && hit_cap) begin
				cap_q <= cap_new[CAP_W-1:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// Open-drain pins
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			rst_n_o_q  <= 1'b0;
			rst_n_oe_q <= 1'b1;
			flt_n_o_q  <= 1'b1;
			flt_n_oe_q <= 1'b0;
		end else if (clk_en) begin
			rst_n_o_q  <= run_d;
			rst_n_oe_q <= !run_d;
			flt_n_o_q  <= !fault_d;
			flt_n_oe_q <= fault_d;
		end
	end

	assign sys_reset_n_o       = rst_n_o_q;
	assign sys_reset_n_oe      = rst_n_oe_q;
	assign watchdog_fault_n_o  = flt_n_o_q;
	assign watchdog_fault_n_oe = flt_n_oe_q;
	assign avs_readdata        = rdata_q;
	assign avs_waitrequest     = wait_q;

endmodule // ssw_supervisor

`default_nettype wire

// file: core/ssw_tick_count.sv
`timescale 1ns/1ps
`default_nettype none

module ssw_tick_count #(
	parameter int W = 32
) (
	input  wire logic         sys_clk,
	input  wire logic         rst,
	input  wire logic         clk_en,
	input  wire logic         clear,
	input  wire logic         run,
	input  wire logic [W-1:0] limit,
	output logic              expired
);

	logic [W-1:0] cnt_q;
	logic [W-1:0] cnt_d;

	// Compare with >= so a limit lowered mid-count still expires
	assign expired = (cnt_q >= limit);
	assign cnt_d   = clear ? '0 : ((run && !expired) ? cnt_q + 1'b1 : cnt_q);

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cnt_q <= '0;
		end else if (clk_en) begin
			cnt_q <= cnt_d;
		end
	end

	if (W < 2) begin : g_chk
		$error("ssw_tick_count: width below 2");
	end

endmodule // ssw_tick_count

`default_nettype wire

// file: tb/ssw_host_model.sv
`timescale 1ns/1ps
`default_nettype none

// Host that services the watchdog with one falling edge per period
module ssw_host_model (
	input wire logic        sys_clk,
	input wire logic        active,
	input wire logic [15:0] period,
	output logic            watchdog_kick_in
);
	logic [15:0] cnt_q = 16'h0000;
	logic        kick_q = 1'b1;
	assign watchdog_kick_in = kick_q;
	// Low phase is half a period: far above the minimum width, and long enough
	// that a design counting rising edges would miss the predicted timeout
	always_ff @(posedge sys_clk) begin
		if (!active || cnt_q >= period - 16'h0001)
			cnt_q <= 16'h0000;
		else
			cnt_q <= cnt_q + 16'h0001;
		kick_q <= !(active && cnt_q >= (period >> 1));
	end
endmodule // ssw_host_model

`default_nettype wire

// file: tb/ssw_sup_props.sv
`timescale 1ns/1ps
`default_nettype none

module ssw_sup_props #(
	parameter int HOLD = 20
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic supply_min_ok,
	input wire logic supply_above_thr,
	input wire logic supply_above_hyst,
	input wire logic manual_reset_n,
	input wire logic manual_reset_n_oe,
	input wire logic watchdog_enable_select,
	input wire logic sys_reset_n_oe,
	input wire logic watchdog_fault_n_oe,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic avs_waitrequest
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);

	logic        sup_ok;
	logic [15:0] ok_len_q;
	logic [15:0] ok_len_d;
	logic [15:0] flt_len_q;
	logic [15:0] flt_len_d;
	// A floating manual input counts as released, like the internal pull-up
	assign sup_ok = supply_min_ok && supply_above_thr && supply_above_hyst
		&& (manual_reset_n || !manual_reset_n_oe);
	assign ok_len_d = sup_ok ? ok_len_q + 16'h0001 : 16'h0000;
	assign flt_len_d = watchdog_fault_n_oe ? flt_len_q + 16'h0001 : 16'h0000;
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ok_len_q <= 16'h0000;
			flt_len_q <= 16'h0000;
		end else begin
			ok_len_q <= ok_len_d;
			flt_len_q <= flt_len_d;
		end
	end

	thr_drop_a: assert property (!supply_above_thr |=> sys_reset_n_oe)
		else $error("reset not asserted after threshold drop");
	minok_low_a: assert property (!supply_min_ok |=> sys_reset_n_oe)
		else $error("reset not asserted below operating level");
	manual_rst_a: assert property ((manual_reset_n_oe && !manual_reset_n) |=> sys_reset_n_oe)
		else $error("reset not asserted by manual input");
	hold_min_a: assert property ($fell(sys_reset_n_oe) |-> int'(ok_len_q) >= HOLD + 2)
		else $error("reset released before hold period");
	hold_max_a: assert property (int'(ok_len_q) > HOLD + 4 |-> !sys_reset_n_oe)
		else $error("reset not released after hold period");
	flt_in_rst_a: assert property (sys_reset_n_oe [*2] |-> !watchdog_fault_n_oe)
		else $error("fault output driven during reset");
	flt_only_a: assert property ($rose(watchdog_fault_n_oe) |-> !sys_reset_n_oe && !$past(sys_reset_n_oe))
		else $error("fault raised with reset asserted");
	flt_len_a: assert property (($fell(watchdog_fault_n_oe) && !sys_reset_n_oe && watchdog_enable_select)
		|-> int'(flt_len_q) inside {[HOLD:HOLD + 1]})
		else $error("fault pulse length wrong");
	sel_off_a: assert property (!watchdog_enable_select [*2] |-> !watchdog_fault_n_oe)
		else $error("fault raised with watchdog disabled");
	bus_wait_a: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
		else $error("bus answer not after one wait cycle");
endmodule // ssw_sup_props

bind ssw_supervisor ssw_sup_props #(.HOLD(HOLD_CYCLES)) u_props (
	.sys_clk(sys_clk), .rst(rst), .supply_min_ok(supply_min_ok),
	.supply_above_thr(supply_above_thr), .supply_above_hyst(supply_above_hyst),
	.manual_reset_n(manual_reset_n), .manual_reset_n_oe(manual_reset_n_oe),
	.watchdog_enable_select(watchdog_enable_select), .sys_reset_n_oe(sys_reset_n_oe),
	.watchdog_fault_n_oe(watchdog_fault_n_oe), .avs_read(avs_read),
	.avs_write(avs_write), .avs_waitrequest(avs_waitrequest));

`default_nettype wire

// file: tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end

module tb_top;
	import ssw_pkg::*;
	localparam int HOLD = 20;
	localparam int OPEN = 60;
	localparam int RES = 40;
	logic sys_clk, rst, min_ok, thr, hyst, mr_n, mr_oe, sel, kick, k_act, ev_on;
	logic rst_n_o, rst_oe, flt_n_o, flt_oe, a_rd, a_wr, a_wait, kick_p, flt_p, rst_p;
	logic [1:0]  cfg;
	logic [3:0]  a_addr, a_be;
	logic [15:0] k_per;
	logic [31:0] a_wd, a_rdata, rd_e, bw;
	int n_fail, n_tests, cyc, last_fall, ev_e, ev_g;
	logic [31:0] rd_q[$];
	int ev_q[$];

	ssw_supervisor #(.HOLD_CYCLES(HOLD), .WD_OPEN_CYCLES(OPEN), .WD_RES_CYCLES(RES),
		.STD_SLOPE_CYCLES(5), .STD_BASE_CYCLES(10), .EXT_SLOPE_CYCLES(7),
		.EXT_BASE_CYCLES(30)) u_dut (
		.sys_clk(sys_clk), .rst(rst), .clk_en(1'b1), .supply_min_ok(min_ok),
		.supply_above_thr(thr), .supply_above_hyst(hyst), .manual_reset_n(mr_n),
		.manual_reset_n_oe(mr_oe), .timeout_config_pin(cfg), .watchdog_enable_select(sel),
		.watchdog_kick_in(kick), .sys_reset_n_o(rst_n_o), .sys_reset_n_oe(rst_oe),
		.watchdog_fault_n_o(flt_n_o), .watchdog_fault_n_oe(flt_oe), .avs_address(a_addr),
		.avs_read(a_rd), .avs_write(a_wr), .avs_writedata(a_wd), .avs_byteenable(a_be),
		.avs_readdata(a_rdata), .avs_waitrequest(a_wait));
	ssw_host_model u_host (.sys_clk(sys_clk), .active(k_act), .period(k_per),
		.watchdog_kick_in(kick));

	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end
	initial begin
		#(100 * 100000);
		n_fail++;
		complete_run();
	end

	// ----------------------------------------------------------------
	// Monitor: each result takes the oldest note of its kind
	// ----------------------------------------------------------------
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (!rst && a_rd && !a_wait) begin
			rd_e = rd_q.pop_front();
			`CHK(a_rdata, rd_e)
		end
		if (kick_p && !kick)
			last_fall = cyc;
		if (!rst && ev_on && ((flt_oe && !flt_p) || (!rst_oe && rst_p))) begin
			ev_e = (ev_q.size() > 0) ? ev_q.pop_front() : -1;
			ev_g = (cyc >= ev_e - 2 && cyc <= ev_e + 3) ? ev_e : cyc;
			`CHK(ev_g, ev_e)
			`CHK(flt_oe ? flt_n_o : !rst_n_o, 1'b0)
		end
		kick_p <= kick;
		flt_p <= flt_oe;
		rst_p <= rst_oe;
	end

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic complete_run();
		$display("Checks: %0d  mismatches: %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
	endtask

	task automatic bus(input logic wr, input logic [3:0] ad, input logic [31:0] d);
		int i;
		@(posedge sys_clk);
		a_addr <= ad;
		a_wd <= d;
		a_rd <= !wr;
		a_wr <= wr;
		for (i = 0; i < 20; i++) begin
			@(posedge sys_clk);
			if (!a_wait)
				break;
		end
		if (i == 20) begin
			n_fail++;
			complete_run();
		end
		a_rd <= 1'b0;
		a_wr <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] ad, input logic [31:0] e);
		rd_q.push_back(e);
		bus(1'b0, ad, 32'h0000_0000);
	endtask

	function automatic int lim_of(input logic [1:0] c, input int x, input int cp);
		if (c == 2'h1)
			return RES;
		if (c == 2'h2)
			return x ? cp * 7 + 30 : cp * 5 + 10;
		return OPEN;
	endfunction

	// Power cycle into one timing class, then starve the watchdog through two timeouts
	task automatic run_case(input logic [1:0] c, input int x, input int cp, input int dip);
		int lim;
		int e1;
		lim = lim_of(c, x, cp);
		@(posedge sys_clk);
		thr <= 1'b0;
		hyst <= 1'b0;
		min_ok <= 1'($urandom % 2);
		tick(4);
		bus(1'b1, REG_CAP, 32'(cp));
		bus(1'b1, REG_CTRL, 32'(x));
		rd(REG_CAP, 32'(cp));
		rd(REG_CTRL, 32'(x));
		cfg <= c;
		k_per <= 16'(lim / 4 + $urandom % (lim / 4));
		min_ok <= 1'b1;
		thr <= 1'b1;
		hyst <= 1'b1;
		if (dip) begin
			tick(10);
			thr <= 1'b0;
			hyst <= 1'b0;
			tick(2);
			thr <= 1'b1;
			hyst <= 1'b1;
		end
		ev_q.push_back(cyc + HOLD + 4);
		tick(3810 + 4 * lim);
		k_act <= 1'b0;
		tick(2);
		e1 = last_fall + lim + 3;
		ev_q.push_back(e1);
		ev_q.push_back(e1 + HOLD + lim + 2);
		tick(e1 + HOLD + lim + 7 - cyc);
		k_act <= 1'b1;
		tick(2 * lim);
	endtask

	initial begin
		rst = 1'b1;
		{min_ok, thr, hyst, mr_oe, a_rd, a_wr} = 6'h00;
		{mr_n, sel, k_act, ev_on} = 4'hf;
		cfg = 2'h0;
		k_per = 16'h0010;
		a_addr = 4'h0;
		a_be = 4'hf;
		a_wd = 32'h0000_0000;
		tick(12);
		rst <= 1'b0;
		void'($urandom(32'hc0f6));
		rd(REG_CAP, 32'(CAP_RESET));
		bus(1'b1, 4'hc, 32'hffff_ffff);
		rd(4'hc, 32'h0000_0000);
		// Only lane 1 written: low byte keeps its reset value
		bw = $urandom;
		a_be <= 4'h2;
		bus(1'b1, REG_CAP, bw);
		a_be <= 4'hf;
		rd(REG_CAP, {18'h0, bw[13:8], CAP_RESET[7:0]});
		run_case(2'h0, 0, 10, 1);
		run_case(2'h1, 0, 10, 0);
		run_case(2'h2, 0, 4, 0);
		run_case(2'h2, 1, 6, 0);
		run_case(2'h3, 0, 10, 0);
		// Disabled watchdog must stay quiet without kicks
		k_act <= 1'b0;
		sel <= 1'b0;
		tick(4 * OPEN);
		// Faults inside the setup window are not predicted; silence after it is
		sel <= 1'b1;
		k_act <= 1'b1;
		ev_on <= 1'b0;
		tick(1500 + 200);
		ev_on <= 1'b1;
		tick(4 * OPEN);
		mr_oe <= 1'b1;
		mr_n <= 1'b0;
		tick(6);
		mr_n <= 1'b1;
		ev_q.push_back(cyc + HOLD + 4);
		tick(HOLD + 10);
		mr_oe <= 1'b0;
		mr_n <= 1'b0;
		tick(4 * OPEN);
		`CHK(ev_q.size(), 0)
		complete_run();
	end
endmodule // tb_top

`default_nettype wire
